// ---- pkg/dsli_pkg.sv ----
package dsli_pkg;
    localparam int CLK_HZ = 100_000_000;
    // Register offsets
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_LEDSEL = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam logic [11:0] ADDR_SIGS = 12'h00C;
    localparam logic [11:0] ADDR_ALARM = 12'h010;
    // CTRL fields
    localparam int CTRL_PULSE_BIT = 0;
    localparam int CTRL_SIM_BIT = 1;
    localparam int CTRL_RET_LSB = 8;
    localparam int CTRL_RET_W = 6;
    localparam logic [5:0] RET_MAX = 6'h32;
    localparam logic [5:0] RET_RESET = 6'h1E;
    // LEDSEL fields
    localparam int SEL_MODE_LSB = 0;
    localparam int SEL_GSRC_LSB = 8;
    localparam int SEL_RSRC_LSB = 16;
    localparam int SEL_GINV_BIT = 24;
    localparam int SEL_RINV_BIT = 25;
    localparam logic [1:0] MODE_DARK = 2'h3;
    localparam logic [1:0] MODE_OUTSIG = 2'h0;
    localparam logic [1:0] MODE_AUTO = 2'h1;
    localparam logic [7:0] SRC_READY = 8'h84;
    localparam logic [7:0] SRC_CONST_OFF = 8'h80;
    localparam logic [7:0] SRC_CONST_ON = 8'h81;
    // SIGS fields
    localparam int SIG_ALARM = 0;
    localparam int SIG_PWRREM = 1;
    localparam int SIG_INFO = 2;
    localparam int SIG_TEACH = 3;
    localparam int SIG_EXEC = 4;
    localparam int SIG_UNLOCK = 5;
    localparam int SIG_COMERR = 6;
    localparam int SIG_STOPCLR = 7;
    localparam int SIG_READY = 8;
    // Timing
    localparam int TICK_US = 100_000;
    localparam int TICK_CYC = TICK_US * (CLK_HZ / 1_000_000);
    localparam int BLINK_ON_T = 3;
    localparam int BLINK_OFF_T = 3;
    localparam int GROUP_GAP_T = 12;
endpackage : dsli_pkg

// ---- src/dsli_blink.sv ----
module dsli_blink #(
    parameter int ON_T = 3,
    parameter int OFF_T = 3,
    parameter int GAP_T = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick,
    input wire logic enable,
    input wire logic [7:0] count,
    output logic lamp
);
    logic [7:0] done_r;
    logic [4:0] ph_r;
    logic gap_r;

    // Blink groups of count pulses, then a gap; count 0 blinks forever
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_r <= 8'h00;
            ph_r <= 5'h00;
            gap_r <= 1'b0;
            lamp <= 1'b0;
        end else if (!enable) begin
            done_r <= 8'h00;
            ph_r <= 5'h00;
            gap_r <= 1'b0;
            lamp <= 1'b0;
        end else if (tick) begin
            if (gap_r) begin
                lamp <= 1'b0;
                if (ph_r == 5'(GAP_T - 1)) begin
                    ph_r <= 5'h00;
                    gap_r <= 1'b0;
                end else begin
                    ph_r <= ph_r + 5'h01;
                end
            end else if (ph_r < 5'(ON_T)) begin
                lamp <= 1'b1;
                ph_r <= ph_r + 5'h01;
            end else if (ph_r == 5'(ON_T + OFF_T - 1)) begin
                lamp <= 1'b0;
                ph_r <= 5'h00;
                if (count != 8'h00 && done_r + 8'h01 >= count) begin
                    done_r <= 8'h00;
                    gap_r <= 1'b1;
                end else begin
                    done_r <= done_r + 8'h01;
                end
            end else begin
                lamp <= 1'b0;
                ph_r <= ph_r + 5'h01;
            end
        end
    end
endmodule : dsli_blink

// ---- src/dsli_tick.sv ----
module dsli_tick #(
    parameter int DIV = 10_000_000
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic tick
);
    logic [23:0] cnt_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 24'h000000;
            tick <= 1'b0;
        end else if (cnt_r == 24'(DIV - 1)) begin
            cnt_r <= 24'h000000;
            tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 24'h000001;
            tick <= 1'b0;
        end
    end
endmodule : dsli_tick

// ---- src/dsli_top.sv ----
// Operation
// - Steady green when powered and idle
// - Alarm blinks red, count gives cause
// - Power removal blinks green until stop-clear
// - Information or teaching: double blink both
// - Interlock release blinks both for retention
// - Retention 0..50 tenths, default 30
// - Switch execution lights both steadily
// - Simulation cycles green, red, both, off
// - Comm ok lights green comm element
// - Comm error lights red comm element
// - Ready LED follows ready output; lit only while pulse_variant_r is set, dark otherwise
// - Mode selects dark, signals or comm
// - Signal mode: green and red follow sources
// - Green source selectable, default ready
// - Red source selectable, default constant off
// - Green invert bit, default off
// - Red invert bit, default off
// - Redirect only on networked variants
//
// Local design decisions: the APB slave port and the address map.
module dsli_top #(
    parameter int TICK_DIV = dsli_pkg::TICK_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic alarm_active,
    input wire logic [7:0] alarm_code,
    input wire logic power_removal,
    input wire logic info_pending,
    input wire logic teach_active,
    input wire logic switch_exec,
    input wire logic unlock_event,
    input wire logic stop_clear_input,
    input wire logic comm_error,
    input wire logic ready_out,
    input wire logic [127:0] out_signals,
    output logic pa_green_r,
    output logic pa_red_r,
    output logic comm_green_r,
    output logic comm_red_r,
    output logic ready_led_r
);
    logic pulse_variant_r;
    logic sim_r;
    logic [5:0] ret_r;
    logic [1:0] mode_r;
    logic [7:0] gsrc_r;
    logic [7:0] rsrc_r;
    logic ginv_r;
    logic rinv_r;
    logic latch_pr_r;
    logic [5:0] unlock_cnt_r;
    logic unlock_r;
    logic [1:0] sim_ph_r;
    logic [2:0] sim_cnt_r;
    logic tick;
    logic alarm_lamp;
    logic single_lamp;
    logic double_lamp;
    logic [31:0] rdata;
    logic wr_en;
    logic [5:0] ret_wr;

    function automatic logic pick_src(input logic [7:0] code, input logic [127:0] sigs,
                                      input logic rdy);
        if (code == dsli_pkg::SRC_CONST_OFF) begin
            pick_src = 1'b0;
        end else if (code == dsli_pkg::SRC_CONST_ON) begin
            pick_src = 1'b1;
        end else if (code == dsli_pkg::SRC_READY) begin
            pick_src = rdy;
        end else if (code[7]) begin
            pick_src = 1'b0;
        end else begin
            pick_src = sigs[code[6:0]];
        end
    endfunction : pick_src

    dsli_tick #(.DIV(TICK_DIV)) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick)
    );

    // Alarm group: blink count is the alarm code
    dsli_blink #(.ON_T(dsli_pkg::BLINK_ON_T), .OFF_T(dsli_pkg::BLINK_OFF_T),
                 .GAP_T(dsli_pkg::GROUP_GAP_T)) u_alarm (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .enable(alarm_active),
        .count(alarm_code),
        .lamp(alarm_lamp)
    );

    dsli_blink #(.ON_T(dsli_pkg::BLINK_ON_T), .OFF_T(dsli_pkg::BLINK_OFF_T),
                 .GAP_T(dsli_pkg::GROUP_GAP_T)) u_single (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .enable(1'b1),
        .count(8'h00),
        .lamp(single_lamp)
    );

    dsli_blink #(.ON_T(dsli_pkg::BLINK_ON_T), .OFF_T(dsli_pkg::BLINK_OFF_T),
                 .GAP_T(dsli_pkg::GROUP_GAP_T)) u_double (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .enable(info_pending | teach_active),
        .count(8'h02),
        .lamp(double_lamp)
    );

    assign wr_en = psel & penable & pwrite;
    // Out-of-range retention values are clamped rather than refused
    assign ret_wr = (pwdata[dsli_pkg::CTRL_RET_LSB +: dsli_pkg::CTRL_RET_W] > dsli_pkg::RET_MAX)
                    ? dsli_pkg::RET_MAX
                    : pwdata[dsli_pkg::CTRL_RET_LSB +: dsli_pkg::CTRL_RET_W];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_variant_r <= 1'b0;
            sim_r <= 1'b0;
            ret_r <= dsli_pkg::RET_RESET;
        end else if (wr_en && paddr == dsli_pkg::ADDR_CTRL) begin
            pulse_variant_r <= pwdata[dsli_pkg::CTRL_PULSE_BIT];
            sim_r <= pwdata[dsli_pkg::CTRL_SIM_BIT];
            ret_r <= ret_wr;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= dsli_pkg::MODE_AUTO;
            gsrc_r <= dsli_pkg::SRC_READY;
            rsrc_r <= dsli_pkg::SRC_CONST_OFF;
            ginv_r <= 1'b0;
            rinv_r <= 1'b0;
        end else if (wr_en && paddr == dsli_pkg::ADDR_LEDSEL) begin
            mode_r <= pwdata[dsli_pkg::SEL_MODE_LSB +: 2];
            gsrc_r <= pwdata[dsli_pkg::SEL_GSRC_LSB +: 8];
            rsrc_r <= pwdata[dsli_pkg::SEL_RSRC_LSB +: 8];
            ginv_r <= pwdata[dsli_pkg::SEL_GINV_BIT];
            rinv_r <= pwdata[dsli_pkg::SEL_RINV_BIT];
        end
    end

    always_comb begin
        rdata = 32'h00000000;
        unique case (paddr)
            dsli_pkg::ADDR_CTRL: begin
                rdata[dsli_pkg::CTRL_PULSE_BIT] = pulse_variant_r;
                rdata[dsli_pkg::CTRL_SIM_BIT] = sim_r;
                rdata[dsli_pkg::CTRL_RET_LSB +: dsli_pkg::CTRL_RET_W] = ret_r;
            end
            dsli_pkg::ADDR_LEDSEL: begin
                rdata[dsli_pkg::SEL_MODE_LSB +: 2] = mode_r;
                rdata[dsli_pkg::SEL_GSRC_LSB +: 8] = gsrc_r;
                rdata[dsli_pkg::SEL_RSRC_LSB +: 8] = rsrc_r;
                rdata[dsli_pkg::SEL_GINV_BIT] = ginv_r;
                rdata[dsli_pkg::SEL_RINV_BIT] = rinv_r;
            end
            dsli_pkg::ADDR_STATUS: begin
                rdata[4:0] = {ready_led_r, comm_red_r, comm_green_r, pa_red_r, pa_green_r};
                rdata[5] = latch_pr_r;
                rdata[6] = unlock_r;
            end
            dsli_pkg::ADDR_SIGS: begin
                rdata[dsli_pkg::SIG_ALARM] = alarm_active;
                rdata[dsli_pkg::SIG_PWRREM] = power_removal;
                rdata[dsli_pkg::SIG_INFO] = info_pending;
                rdata[dsli_pkg::SIG_TEACH] = teach_active;
                rdata[dsli_pkg::SIG_EXEC] = switch_exec;
                rdata[dsli_pkg::SIG_UNLOCK] = unlock_event;
                rdata[dsli_pkg::SIG_COMERR] = comm_error;
                rdata[dsli_pkg::SIG_STOPCLR] = stop_clear_input;
                rdata[dsli_pkg::SIG_READY] = ready_out;
            end
            dsli_pkg::ADDR_ALARM: rdata[7:0] = alarm_code;
            default: rdata = 32'h00000000;
        endcase
    end

    // Zero-wait slave; unmapped addresses answer with an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            prdata <= rdata;
            pslverr <= psel & ~penable & (paddr > dsli_pkg::ADDR_ALARM | paddr[1:0] != 2'h0);
        end
    end

    // Power removal indication holds until stop-clear after release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_pr_r <= 1'b0;
        end else if (power_removal) begin
            latch_pr_r <= 1'b1;
        end else if (stop_clear_input) begin
            latch_pr_r <= 1'b0;
        end
    end

    // Retention timer counts tenths of seconds from the tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unlock_r <= 1'b0;
            unlock_cnt_r <= 6'h00;
        end else if (unlock_event) begin
            unlock_r <= (ret_r != 6'h00);
            unlock_cnt_r <= ret_r;
        end else if (unlock_r && tick) begin
            if (unlock_cnt_r <= 6'h01) begin
                unlock_r <= 1'b0;
                unlock_cnt_r <= 6'h00;
            end else begin
                unlock_cnt_r <= unlock_cnt_r - 6'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sim_ph_r <= 2'h0;
            sim_cnt_r <= 3'h0;
        end else if (!sim_r) begin
            sim_ph_r <= 2'h0;
            sim_cnt_r <= 3'h0;
        end else if (tick) begin
            if (sim_cnt_r == 3'(dsli_pkg::BLINK_ON_T - 1)) begin
                sim_cnt_r <= 3'h0;
                sim_ph_r <= sim_ph_r + 2'h1;
            end else begin
                sim_cnt_r <= sim_cnt_r + 3'h1;
            end
        end
    end

    // Power/alarm priority chain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pa_green_r <= 1'b0;
            pa_red_r <= 1'b0;
        end else if (sim_r) begin
            pa_green_r <= (sim_ph_r == 2'h0) | (sim_ph_r == 2'h2);
            pa_red_r <= (sim_ph_r == 2'h1) | (sim_ph_r == 2'h2);
        end else if (alarm_active) begin
            pa_green_r <= 1'b0;
            pa_red_r <= alarm_lamp;
        end else if (latch_pr_r) begin
            pa_green_r <= single_lamp;
            pa_red_r <= 1'b0;
        end else if (switch_exec) begin
            pa_green_r <= 1'b1;
            pa_red_r <= 1'b1;
        end else if (unlock_r) begin
            pa_green_r <= single_lamp;
            pa_red_r <= single_lamp;
        end else if (info_pending | teach_active) begin
            pa_green_r <= double_lamp;
            pa_red_r <= double_lamp;
        end else begin
            pa_green_r <= 1'b1;
            pa_red_r <= 1'b0;
        end
    end

    // Comm LED source selection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comm_green_r <= 1'b0;
            comm_red_r <= 1'b0;
        end else if (mode_r == dsli_pkg::MODE_DARK) begin
            comm_green_r <= 1'b0;
            comm_red_r <= 1'b0;
        end else if (mode_r == dsli_pkg::MODE_AUTO && !pulse_variant_r) begin
            comm_green_r <= ~comm_error;
            comm_red_r <= comm_error;
        end else begin
            comm_green_r <= pick_src(gsrc_r, out_signals, ready_out) ^ ginv_r;
            comm_red_r <= pick_src(rsrc_r, out_signals, ready_out) ^ rinv_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_led_r <= 1'b0;
        end else begin
            ready_led_r <= pulse_variant_r & ready_out;
        end
    end

    exec_both_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!sim_r && !alarm_active && !latch_pr_r && switch_exec) |=> (pa_green_r && pa_red_r))
        else $error("switch exec not both lit");
    idle_green_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!sim_r && !alarm_active && !latch_pr_r && !switch_exec && !unlock_r
         && !info_pending && !teach_active) |=> (pa_green_r && !pa_red_r))
        else $error("idle not steady green");
    alarm_red_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!sim_r && alarm_active) |=> !pa_green_r)
        else $error("green lit during alarm");
    prem_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (latch_pr_r && !power_removal && !stop_clear_input) |=> latch_pr_r)
        else $error("power removal dropped early");
    ready_led_a: assert property (@(posedge pclk) disable iff (!presetn)
        pulse_variant_r && $stable(pulse_variant_r) |=> ready_led_r == $past(ready_out))
        else $error("ready led mismatch");
    comm_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_r == dsli_pkg::MODE_AUTO && !pulse_variant_r && comm_error && !wr_en)
        |=> (comm_red_r && !comm_green_r))
        else $error("comm error not red");
    comm_dark_a: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_r == dsli_pkg::MODE_DARK && !wr_en) |=> (!comm_green_r && !comm_red_r))
        else $error("dark mode lit");
    ret_range_a: assert property (@(posedge pclk) disable iff (!presetn)
        ret_r <= dsli_pkg::RET_MAX)
        else $error("retention out of range");
    unlock_end_a: assert property (@(posedge pclk) disable iff (!presetn)
        (unlock_r && !unlock_event && tick && unlock_cnt_r == 6'h01) |=> !unlock_r)
        else $error("unlock did not expire");
endmodule : dsli_top

// ---- test/dsli_panel_model.sv ----
// Operator's view of the power/alarm lamp: counts changes and blink groups
module dsli_panel_model #(
    parameter int GAP_CYC = 20
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clr,
    input wire logic green,
    input wire logic red,
    output int g_chg,
    output int r_chg,
    output int grp,
    output logic [7:0] hist
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pg, pr;
    int cnt, off_run;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn || clr) begin
            g_chg <= 0;
            r_chg <= 0;
            grp <= 0;
            cnt <= 0;
            off_run <= 0;
            hist <= 8'h00;
            pg <= green;
            pr <= red;
        end else begin
            pg <= green;
            pr <= red;
            if (green !== pg) g_chg <= g_chg + 1;
            if (red !== pr) r_chg <= r_chg + 1;
            if ({green, red} !== {pg, pr}) hist <= {hist[5:0], green, red};
            if (red && !pr) cnt <= cnt + 1;
            off_run <= red ? 0 : off_run + 1;
            // A long dark spell closes a group of blinks
            if (!red && off_run == GAP_CYC && cnt != 0) begin
                grp <= cnt;
                cnt <= 0;
            end
        end
    end
endmodule : dsli_panel_model

// ---- test/tb_dsli_top.sv ----
module tb_dsli_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TDIV = 4;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err;
    logic alarm_active = 1'b0, power_removal = 1'b0, info_pending = 1'b0;
    logic teach_active = 1'b0, switch_exec = 1'b0, unlock_event = 1'b0;
    logic stop_clear_input = 1'b0, comm_error = 1'b0, ready_out = 1'b0, clr = 1'b0;
    logic [7:0] alarm_code = 8'h00;
    logic [127:0] out_signals = 128'h0;
    logic pa_green_r, pa_red_r, comm_green_r, comm_red_r, ready_led_r;
    logic [7:0] hist;
    int g_chg, r_chg, grp;
    int n_fail = 0;
    int cmp_count = 0;

    always #5 pclk = ~pclk;

    dsli_top #(.TICK_DIV(TDIV)) u_dsli_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .alarm_active(alarm_active),
        .alarm_code(alarm_code), .power_removal(power_removal), .info_pending(info_pending),
        .teach_active(teach_active), .switch_exec(switch_exec), .unlock_event(unlock_event),
        .stop_clear_input(stop_clear_input), .comm_error(comm_error), .ready_out(ready_out),
        .out_signals(out_signals), .pa_green_r(pa_green_r), .pa_red_r(pa_red_r),
        .comm_green_r(comm_green_r), .comm_red_r(comm_red_r), .ready_led_r(ready_led_r));

    dsli_panel_model u_dsli_panel_model (.pclk(pclk), .presetn(presetn), .clr(clr),
        .green(pa_green_r), .red(pa_red_r), .g_chg(g_chg), .r_chg(r_chg), .grp(grp),
        .hist(hist));

    task automatic report_and_stop();
        $display("compared %0d, mismatched %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc

    // Zero wait states expected, but never assumed
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            chk(32'h00000000, 32'h00000001, "pready timeout");
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic experr);
        apb(1'b0, a, 32'h00000000);
        chk(rd, exp, "read data");
        chk({31'h00000000, err}, {31'h00000000, experr}, "slave error");
    endtask : rchk

    task automatic lamps(input logic [3:0] exp, input string what);
        chk({28'h0000000, pa_green_r, pa_red_r, comm_green_r, comm_red_r},
            {28'h0000000, exp}, what);
    endtask : lamps

    // Steady means unchanged for 30 cycles, longer than any 12-cycle blink on or off phase
    task automatic steady(input logic g, input logic r);
        int run;
        run = 0;
        for (int i = 0; i < 400 && run < 30; i++) begin
            @(posedge pclk);
            run = (pa_green_r === g && pa_red_r === r) ? run + 1 : 0;
        end
        chk({31'h00000000, run == 30}, 32'h00000001, "steady lamp");
    endtask : steady

    task automatic watch(input int n);
        @(posedge pclk);
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        cyc(n);
    endtask : watch

    initial begin
        cyc(20000);
        chk(32'h00000000, 32'h00000001, "run timeout");
        report_and_stop();
    end

    initial begin
        cyc(3);
        presetn <= 1'b1;
        cyc(2);
        rchk(dsli_pkg::ADDR_CTRL, 32'h00001E00, 1'b0);
        rchk(dsli_pkg::ADDR_LEDSEL, 32'h00808401, 1'b0);
        rchk(12'h014, 32'h00000000, 1'b1);
        rchk(12'h002, 32'h00000000, 1'b1);
        steady(1'b1, 1'b0);
        lamps(4'hA, "idle");
        comm_error <= 1'b1;
        cyc(3);
        lamps(4'h9, "comm error");
        rchk(dsli_pkg::ADDR_STATUS, 32'h00000009, 1'b0);
        rchk(dsli_pkg::ADDR_SIGS, 32'h00000040, 1'b0);
        comm_error <= 1'b0;
        cyc(3);
        lamps(4'hA, "comm back");
        apb(1'b1, dsli_pkg::ADDR_LEDSEL, 32'h00808400);
        ready_out <= 1'b1;
        cyc(3);
        lamps(4'hA, "default sources on");
        ready_out <= 1'b0;
        cyc(3);
        lamps(4'h8, "default sources off");
        apb(1'b1, dsli_pkg::ADDR_LEDSEL, 32'h00810500);
        out_signals[5] <= 1'b1;
        cyc(3);
        lamps(4'hB, "signal on");
        out_signals[5] <= 1'b0;
        cyc(3);
        lamps(4'h9, "signal off");
        apb(1'b1, dsli_pkg::ADDR_LEDSEL, 32'h03810500);
        cyc(3);
        lamps(4'hA, "inverted");
        apb(1'b1, dsli_pkg::ADDR_LEDSEL, 32'h03810503);
        cyc(3);
        lamps(4'h8, "dark");
        rchk(dsli_pkg::ADDR_LEDSEL, 32'h03810503, 1'b0);
        apb(1'b1, dsli_pkg::ADDR_LEDSEL, 32'h00808401);
        apb(1'b1, dsli_pkg::ADDR_CTRL, 32'h00001E01);
        ready_out <= 1'b1;
        cyc(3);
        chk({31'h00000000, ready_led_r}, 32'h00000001, "ready lit");
        ready_out <= 1'b0;
        cyc(3);
        chk({31'h00000000, ready_led_r}, 32'h00000000, "ready dark");
        lamps(4'h8, "pulse variant sources");
        apb(1'b1, dsli_pkg::ADDR_CTRL, 32'h00003F00);
        rchk(dsli_pkg::ADDR_CTRL, 32'h00003200, 1'b0);
        apb(1'b1, dsli_pkg::ADDR_CTRL, 32'h00000A00);
        alarm_code <= 8'h02;
        alarm_active <= 1'b1;
        switch_exec <= 1'b1;
        watch(300);
        chk(32'(grp), 32'h00000002, "alarm blink group");
        rchk(dsli_pkg::ADDR_ALARM, 32'h00000002, 1'b0);
        alarm_active <= 1'b0;
        steady(1'b1, 1'b1);
        switch_exec <= 1'b0;
        steady(1'b1, 1'b0);
        power_removal <= 1'b1;
        watch(100);
        chk({31'h00000000, g_chg >= 4}, 32'h00000001, "removal blink");
        power_removal <= 1'b0;
        watch(100);
        chk({31'h00000000, g_chg >= 4}, 32'h00000001, "blink until clear");
        stop_clear_input <= 1'b1;
        cyc(2);
        stop_clear_input <= 1'b0;
        steady(1'b1, 1'b0);
        for (int k = 0; k < 2; k++) begin
            info_pending <= (k == 0);
            teach_active <= (k == 1);
            watch(300);
            chk(32'(grp), 32'h00000002, "double blink");
            info_pending <= 1'b0;
            teach_active <= 1'b0;
            steady(1'b1, 1'b0);
        end
        unlock_event <= 1'b1;
        cyc(1);
        unlock_event <= 1'b0;
        watch(30);
        chk({31'h00000000, g_chg >= 1 && r_chg >= 1}, 32'h00000001, "unlock blink");
        steady(1'b1, 1'b0);
        apb(1'b1, dsli_pkg::ADDR_CTRL, 32'h00000000);
        unlock_event <= 1'b1;
        cyc(1);
        unlock_event <= 1'b0;
        watch(40);
        chk(32'(r_chg), 32'h00000000, "zero retention");
        apb(1'b1, dsli_pkg::ADDR_CTRL, 32'h00000002);
        watch(0);
        for (int i = 0; i < 200 && hist !== 8'h9C; i++) @(posedge pclk);
        chk({24'h000000, hist}, 32'h0000009C, "simulation cycle");
        apb(1'b1, dsli_pkg::ADDR_CTRL, 32'h00001E00);
        steady(1'b1, 1'b0);
        report_and_stop();
    end
endmodule : tb_dsli_top
